/* hw/wxt_core.sv */
// Notes on behaviour
// - deferred cycle: config to 3.6-3.1, index_sum low
// - change of sequence: fetch, flow tag, next address
// - jump: data_addr low, next address high
// - io select cfg1: fetch bits into 3.6-3.1
// - file loads: config 9-1 into 4.9-4.1
// - file ops rotate exchange quarters per step
// - zero merge: only buffer zeros reach exchange
// - jam buffer to exchange at 21/23
// - invert, file store, assembly: jam at 13
// - flipflop space use: jam buffer to exchange
// - deferred cycle: jam at instruction level 11
// - skip differ: xor twice, exchange restored
// - arith instruction at level 10, wait busy
// - arith operand at data level 03 if idle
// - io in or select cfg1: jam from input mixer
// - store: masked quarters exchange to buffer at 13
// - merge into: zeros at 13, ones at 19
// - io normal, bit skip cfg3: exchange to buffer
// - load: masked quarters buffer to exchange at 13
// - assembly: no config, cycle one place by direction
// - clear buffer at 18 for assembly, bit skip cfg3 or any other op without flipflop space use, unless alarm lock
// - assembly, bit skip cfg3: cycle into buffer at 19
// - alarm lock blocks every buffer change
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "wxt_params.svh"

module wxt_core
  import wxt_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  input  wire logic [3:0]         op_class,
  input  wire logic [1:0]         io_mode,
  input  wire logic [8:0]         data_cycle_config,
  input  wire logic [8:0]         instr_cycle_config,
  input  wire logic [4:0]         data_cycle_timer,
  input  wire logic               data_alpha,
  input  wire logic [4:0]         instr_cycle_timer,
  input  wire logic               instr_alpha,
  input  wire logic               file_step_timer,
  input  wire logic               file_rot_left,
  input  wire logic               defer_cycle,
  input  wire logic               chg_seq_cycle,
  input  wire logic               uses_flipflop_space,
  input  wire logic               instr_in_arith,
  input  wire logic               operand_in_arith,
  input  wire logic               arith_busy,
  input  wire logic [35:0]        arith_word,
  input  wire logic [35:0]        io_input_mixer,
  input  wire logic               shift_dir_level,
  input  wire logic [17:0]        index_sum,
  input  wire logic [17:0]        next_instr_addr,
  input  wire logic [17:0]        data_addr,
  input  wire logic [35:0]        fetch_word,
  input  wire logic [35:0]        flow_tag,
  input  wire logic               mem_strobe,
  input  wire logic [35:0]        mem_word,
  input  wire logic               store_alarm_lock,
  output logic [35:0]             exch_word_ff,
  output logic [35:0]             buf_word_ff,
  output logic                    instr_wait_ff,
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // ********************************************************
  // decode
  // ********************************************************
  wire wxt_op_e op = wxt_op_e'(op_class);
  wire logic ff_store  = (op == OP_FSTORE_FUL) || (op == OP_FSTORE_HLF);
  wire logic ff_load   = (op == OP_FLOAD_FULL) || (op == OP_FLOAD_HALF);
  wire logic st_type   = (op == OP_STORE) || ff_store;
  wire logic ld_type   = (op == OP_LOAD) || ff_load;
  wire logic assembly  = (op == OP_IO_MOVE) && (io_mode == IOM_ASSEMBLY);
  wire logic io_normal = (op == OP_IO_MOVE) && (io_mode == IOM_NORMAL);
  wire logic io_in     = (op == OP_IO_MOVE) && (io_mode == IOM_IN);
  wire logic skm_cf3   = (op == OP_BIT_SKIP) &&
                         instr_cycle_config[`WXT_CF_BIT3];
  wire logic ios_cf1   = (op == OP_IO_SELECT) &&
                         instr_cycle_config[`WXT_CF_BIT1];

  wire logic d_at03 = data_alpha && (data_cycle_timer == `WXT_DCT_ARITH);
  wire logic d_at13 = data_alpha && (data_cycle_timer == `WXT_DCT_XFER);
  wire logic d_at15 = data_alpha && (data_cycle_timer == `WXT_DCT_SED2);
  wire logic d_at18 = data_alpha && (data_cycle_timer == `WXT_DCT_CLEAR);
  wire logic d_at19 = data_alpha && (data_cycle_timer == `WXT_DCT_CYCLE);
  wire logic d_at21 = data_alpha && (data_cycle_timer == `WXT_DCT_STJAM);
  wire logic d_at23 = data_alpha && (data_cycle_timer == `WXT_DCT_LDJAM);
  wire logic i_at10 = instr_alpha && (instr_cycle_timer == `WXT_ICT_ARITH);
  wire logic i_at11 = instr_alpha && (instr_cycle_timer == `WXT_ICT_DEFJAM);
  wire logic i_at12 = instr_alpha && (instr_cycle_timer == `WXT_ICT_MISC);
  wire logic i_lv10 = (instr_cycle_timer == `WXT_ICT_ARITH);

  // ********************************************************
  // quarter activity masks
  // ********************************************************
  logic [3:0] prm_act_ff;
  logic [35:0] act_mask;
  genvar gq;
  generate
    for (gq = 0; gq < 4; gq = gq + 1) begin : g_mask
      assign act_mask[gq*`WXT_QW +: `WXT_QW] =
        {`WXT_QW{prm_act_ff[gq]}};
    end
  endgenerate

  wire logic [35:0] ex = exch_word_ff;
  wire logic [35:0] bf = buf_word_ff;
  wire logic [35:0] ex_rot_r = {ex[`WXT_QW-1:0], ex[35:`WXT_QW]};
  wire logic [35:0] ex_rot_l = {ex[35-`WXT_QW:0], ex[35:36-`WXT_QW]};
  wire logic [35:0] ex_cyc_r = {ex[0], ex[35:1]};
  wire logic [35:0] ex_cyc_l = {ex[34:0], ex[35]};

  // ********************************************************
  // exchange word next value
  // ********************************************************
  logic [35:0] nxt_exch;
  always_comb begin
    nxt_exch = ex;
    if (defer_cycle && i_at11) begin
      nxt_exch = bf;
    end else if (defer_cycle && i_at12) begin
      nxt_exch[`WXT_Q3_HI6:`WXT_Q3_LO] =
        data_cycle_config[5:0];
      nxt_exch[`WXT_HALF-1:0] = index_sum;
    end else if (chg_seq_cycle && i_at12) begin
      nxt_exch[`WXT_Q3_HI6:`WXT_Q3_LO] =
        fetch_word[`WXT_Q3_HI6:`WXT_Q3_LO];
      nxt_exch[`WXT_Q4_HI6:`WXT_Q4_LO] =
        flow_tag[`WXT_Q3_HI6:`WXT_Q3_LO];
      nxt_exch[`WXT_HALF-1:0] = next_instr_addr;
    end else if (instr_in_arith && i_at10 && !arith_busy) begin
      nxt_exch = arith_word;
    end else if (uses_flipflop_space && (i_at11 || d_at13)) begin
      nxt_exch = bf;
    end else if ((op == OP_JUMP) && i_at12) begin
      if (instr_cycle_config[`WXT_CF_BIT4]) begin
        nxt_exch[`WXT_HALF-1:0] = data_addr;
      end
      if (instr_cycle_config[`WXT_CF_BIT5]) begin
        nxt_exch[35:`WXT_HALF] = next_instr_addr;
      end
    end else if (ios_cf1 && i_at12) begin
      nxt_exch[`WXT_Q3_HI6:`WXT_Q3_LO] =
        fetch_word[`WXT_Q3_HI6:`WXT_Q3_LO];
    end else if (operand_in_arith && !arith_busy && d_at03) begin
      nxt_exch = arith_word;
    end else if ((io_in || ios_cf1) && d_at13) begin
      nxt_exch = io_input_mixer;
    end else if (ff_load && d_at03) begin
      nxt_exch[`WXT_Q4_HI9:`WXT_Q4_LO] = data_cycle_config;
    end else if ((op == OP_ZERO_MERGE) && d_at13) begin
      nxt_exch = ex & bf;
    end else if (((op == OP_INVERT) || ff_store || assembly) &&
                 d_at13) begin
      nxt_exch = bf;
    end else if ((op == OP_SKIP_DIFF) && (d_at13 || d_at15)) begin
      nxt_exch = ex ^ (bf & act_mask);
    end else if ((ld_type || ((op == OP_BIT_SKIP) && !skm_cf3)) &&
                 d_at13) begin
      nxt_exch = (bf & act_mask) | (ex & ~act_mask);
    end else if ((st_type && d_at21) || (ld_type && d_at23)) begin
      nxt_exch = bf;
    end else if ((ff_store || ff_load) && file_step_timer) begin
      nxt_exch = file_rot_left ? ex_rot_l : ex_rot_r;
    end
  end

  // ********************************************************
  // operand buffer next value
  // ********************************************************
  wire logic clr_cond = assembly || skm_cf3 ||
                        ((op != OP_NONE) && !uses_flipflop_space);
  logic [35:0] nxt_buf;
  always_comb begin
    nxt_buf = bf;
    if (mem_strobe) begin
      nxt_buf = mem_word;
    end else if (d_at18 && clr_cond) begin
      nxt_buf = '0;
    end else if (d_at19 && (assembly || skm_cf3)) begin
      nxt_buf = shift_dir_level ? ex_cyc_r : ex_cyc_l;
    end else if ((op == OP_MERGE_INTO) && d_at13) begin
      nxt_buf = bf & (ex | ~act_mask);
    end else if ((op == OP_MERGE_INTO) && d_at19) begin
      nxt_buf = bf | (ex & act_mask);
    end else if ((st_type || io_normal || skm_cf3) && d_at13) begin
      nxt_buf = (ex & act_mask) | (bf & ~act_mask);
    end
  end

  // ********************************************************
  // datapath registers
  // ********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exch_word_ff  <= '0;
      buf_word_ff   <= '0;
      instr_wait_ff <= 1'b0;
    end else if (clk_en) begin
      exch_word_ff  <= nxt_exch;
      if (!store_alarm_lock) begin
        buf_word_ff <= nxt_buf;
      end
      instr_wait_ff <= instr_in_arith && i_lv10 && arith_busy;
    end
  end

  // ********************************************************
  // axi4-lite slave
  // ********************************************************
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take  = s_axi_wvalid && s_axi_wready;
  wire logic aw_now  = aw_have_ff || aw_take;
  wire logic w_now   = w_have_ff || w_take;
  wire logic [31:0] wa = aw_have_ff ? awaddr_ff : s_axi_awaddr;
  wire logic [31:0] wd = w_have_ff ? wdata_ff : s_axi_wdata;
  wire logic [3:0]  ws = w_have_ff ? wstrb_ff : s_axi_wstrb;
  wire logic do_wr   = aw_now && w_now && !s_axi_bvalid;
  wire logic wr_ctrl = (wa[31:`WXT_AMSB] == '0) &&
                       (wa[3:0] == `WXT_OFF_CTRL) && !wa[4];
  wire logic [3:0] nxt_prm = ws[0] ? wd[3:0] : prm_act_ff;

  wire logic [31:0] ra = s_axi_araddr;
  wire logic ra_hi = (ra[31:6] == '0);
  wire logic ra_lo = ra_hi && !ra[4] && !ra[5];
  wire logic [31:0] rd_ctrl = {28'h0000000, prm_act_ff};
  wire logic [31:0] rd_stat = {30'h00000000, store_alarm_lock,
                               instr_wait_ff};
  wire logic [31:0] rd_exhi = {28'h0000000, ex[35:32]};
  wire logic [31:0] rd_bfhi = {28'h0000000, bf[35:32]};
  logic [31:0] rd_val;
  logic        rd_ok;
  assign rd_ok = ra_lo || (ra_hi &&
                 ((ra[5:0] == `WXT_OFF_BFLO) ||
                  (ra[5:0] == `WXT_OFF_BFHI)));
  assign rd_val = !rd_ok ? 32'h00000000 :
                  (ra[5:0] == `WXT_OFF_BFLO) ? bf[31:0] :
                  (ra[5:0] == `WXT_OFF_BFHI) ? rd_bfhi :
                  (ra[3:0] == `WXT_OFF_CTRL) ? rd_ctrl :
                  (ra[3:0] == `WXT_OFF_STAT) ? rd_stat :
                  (ra[3:0] == `WXT_OFF_EXLO) ? ex[31:0] :
                  rd_exhi;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= '0;
      wstrb_ff      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WXT_RESP_OK;
      prm_act_ff    <= `WXT_CTRL_RST;
    end else if (clk_en) begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      aw_have_ff    <= aw_now && !do_wr;
      w_have_ff     <= w_now && !do_wr;
      s_axi_awready <= !aw_now && !s_axi_bvalid && !aw_take;
      s_axi_wready  <= !w_now && !s_axi_bvalid && !w_take;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ctrl ? `WXT_RESP_OK : `WXT_RESP_ERR;
        if (wr_ctrl) begin
          prm_act_ff <= nxt_prm;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `WXT_RESP_OK;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? `WXT_RESP_OK : `WXT_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* hw/wxt_params.svh */
`ifndef WXT_PARAMS_SVH
`define WXT_PARAMS_SVH

// word layout: four quarters of nine bits
`define WXT_QW          9
`define WXT_WW          36
`define WXT_HALF        18
`define WXT_Q3_LO       18
`define WXT_Q3_HI6      23
`define WXT_Q4_LO       27
`define WXT_Q4_HI6      32
`define WXT_Q4_HI9      35

// time levels (alpha strobes)
`define WXT_DCT_ARITH   5'h03
`define WXT_DCT_XFER    5'h0d
`define WXT_DCT_SED2    5'h0f
`define WXT_DCT_CLEAR   5'h12
`define WXT_DCT_CYCLE   5'h13
`define WXT_DCT_STJAM   5'h15
`define WXT_DCT_LDJAM   5'h17
`define WXT_ICT_ARITH   5'h0a
`define WXT_ICT_DEFJAM  5'h0b
`define WXT_ICT_MISC    5'h0c

// configuration bit positions
`define WXT_CF_BIT1     0
`define WXT_CF_BIT3     2
`define WXT_CF_BIT4     3
`define WXT_CF_BIT5     4

// register byte offsets
`define WXT_OFF_CTRL    4'h0
`define WXT_OFF_STAT    4'h4
`define WXT_OFF_EXLO    4'h8
`define WXT_OFF_EXHI    4'hc
`define WXT_AMSB        5
`define WXT_OFF_BFLO    6'h10
`define WXT_OFF_BFHI    6'h14
`define WXT_CTRL_RST    4'hf

// axi responses
`define WXT_RESP_OK     2'h0
`define WXT_RESP_ERR    2'h2

`endif

/* hw/wxt_pkg.sv */
package wxt_pkg;

  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_LOAD       = 4'h1,
    OP_STORE      = 4'h2,
    OP_JUMP       = 4'h3,
    OP_IO_SELECT  = 4'h4,
    OP_FLOAD_FULL = 4'h5,
    OP_FLOAD_HALF = 4'h6,
    OP_FSTORE_FUL = 4'h7,
    OP_FSTORE_HLF = 4'h8,
    OP_ZERO_MERGE = 4'h9,
    OP_INVERT     = 4'ha,
    OP_IO_MOVE    = 4'hb,
    OP_SKIP_DIFF  = 4'hc,
    OP_MERGE_INTO = 4'hd,
    OP_BIT_SKIP   = 4'he
  } wxt_op_e;

  typedef enum logic [1:0] {
    IOM_NORMAL   = 2'h0,
    IOM_ASSEMBLY = 2'h1,
    IOM_IN       = 2'h2
  } wxt_iomode_e;

endpackage

/* testbench/wxt_far_model.sv */
`timescale 1ns/100ps
module wxt_far_model (
  input  wire logic        aclk,
  input  wire logic        slow,
  output logic [35:0]      arith_word,
  output logic [35:0]      io_input_mixer,
  output logic             arith_busy
);
  // ****
  // far elements
  // ****
  initial begin
    arith_word = 36'h93c1e5a87;
    io_input_mixer = 36'h4d2b60f19;
  end
  // results keep moving while the element is busy
  always @(posedge aclk) begin
    arith_busy <= slow;
    if (slow) begin
      arith_word <= {arith_word[34:0], ~arith_word[35] ^ arith_word[26]};
      io_input_mixer <= ~{io_input_mixer[0], io_input_mixer[35:1]};
    end
  end
endmodule

/* testbench/wxt_core_asserts.sv */
`timescale 1ns/100ps
module wxt_core_chk
  import wxt_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic [3:0]  op_class,
  input wire logic [4:0]  data_cycle_timer,
  input wire logic        data_alpha,
  input wire logic [4:0]  instr_cycle_timer,
  input wire logic        instr_alpha,
  input wire logic        defer_cycle,
  input wire logic        chg_seq_cycle,
  input wire logic        uses_flipflop_space,
  input wire logic        file_step_timer,
  input wire logic        operand_in_arith,
  input wire logic        arith_busy,
  input wire logic [35:0] arith_word,
  input wire logic [17:0] index_sum,
  input wire logic        mem_strobe,
  input wire logic        store_alarm_lock,
  input wire logic [35:0] exch_word_ff,
  input wire logic [35:0] buf_word_ff,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid
);
  // ****
  // checks
  // ****
  logic dq;
  assign dq = clk_en && data_alpha && !instr_alpha && !defer_cycle
    && !chg_seq_cycle && !uses_flipflop_space && !file_step_timer;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_op_at(logic [3:0] o, logic [4:0] t);
    dq && op_class == o && data_cycle_timer == t;
  endsequence
  sequence s_defer_at(logic [4:0] t);
    clk_en && instr_alpha && defer_cycle && instr_cycle_timer == t;
  endsequence
  sequence s_wr_taken;
    clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_load_jam: assert property (s_op_at(OP_LOAD, 5'h17)
    |=> exch_word_ff == $past(buf_word_ff)) else $error("load jam");
  a_store_jam: assert property (s_op_at(OP_STORE, 5'h15)
    |=> exch_word_ff == $past(buf_word_ff)) else $error("store jam");
  a_invert_jam: assert property (s_op_at(OP_INVERT, 5'h0d)
    |=> exch_word_ff == $past(buf_word_ff)) else $error("invert jam");
  a_zero_merge: assert property (s_op_at(OP_ZERO_MERGE, 5'h0d)
    |=> exch_word_ff == ($past(exch_word_ff) & $past(buf_word_ff)))
    else $error("zero merge");
  a_arith_oper: assert property (s_op_at(OP_NONE, 5'h03)
    ##0 (operand_in_arith && !arith_busy)
    |=> exch_word_ff == $past(arith_word)) else $error("arith operand");
  a_store_clear: assert property (s_op_at(OP_STORE, 5'h12)
    ##0 (!mem_strobe && !store_alarm_lock) |=> buf_word_ff == 36'h0)
    else $error("buffer clear");
  a_lock_blocks: assert property (clk_en && store_alarm_lock
    |=> $stable(buf_word_ff)) else $error("locked buffer changed");
  a_defer_jam: assert property (s_defer_at(5'h0b)
    |=> exch_word_ff == $past(buf_word_ff)) else $error("defer jam");
  a_defer_index: assert property (s_defer_at(5'h0c)
    |=> exch_word_ff[17:0] == $past(index_sum)) else $error("defer index");
  a_bresp_after: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("no write response");
endmodule
bind wxt_core wxt_core_chk wxt_core_chk_i (.*);

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  import wxt_pkg::*;
  // ****
  // bench
  // ****
  logic        aclk, aresetn, clk_en, data_alpha, instr_alpha, slow;
  logic        file_step_timer, file_rot_left, defer_cycle, chg_seq_cycle;
  logic        uses_flipflop_space, instr_in_arith, operand_in_arith;
  logic        shift_dir_level, mem_strobe, store_alarm_lock, arith_busy;
  logic        instr_wait_ff, chk_dp, chk_sel;
  logic [3:0]  op_class, s_axi_wstrb;
  logic [1:0]  io_mode, s_axi_bresp, s_axi_rresp;
  logic [8:0]  data_cycle_config, instr_cycle_config;
  logic [4:0]  data_cycle_timer, instr_cycle_timer;
  logic [17:0] index_sum, next_instr_addr, data_addr;
  logic [35:0] fetch_word, flow_tag, mem_word, exch_word_ff, buf_word_ff;
  logic [35:0] arith_word, io_input_mixer, bv, ev;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [37:0] q[$];
  int          failures, checks, tn, seed;
  wxt_op_e     ops [4] = '{OP_INVERT, OP_FSTORE_FUL, OP_FSTORE_HLF, OP_IO_MOVE};

  wxt_core wxt_core_i (.*);
  wxt_far_model wxt_far_model_i (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic cmp(input logic [37:0] got);
    logic [37:0] e;
    e = q.size() ? q.pop_front() : ~got;
    checks++;
    if (e !== got) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp({36'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) cmp({4'h0, s_axi_rresp, s_axi_rdata});
    if (chk_dp) cmp({2'h0, chk_sel ? buf_word_ff : exch_word_ff});
  end

  task automatic rnd();
    data_cycle_config <= 9'($random(seed));
    instr_cycle_config <= 9'($random(seed));
    index_sum <= 18'($random(seed));
    next_instr_addr <= 18'($random(seed));
    data_addr <= 18'($random(seed));
    fetch_word <= {4'($random(seed)), 32'($random(seed))};
    flow_tag <= {4'($random(seed)), 32'($random(seed))};
    mem_word <= {4'($random(seed)), 32'($random(seed))};
  endtask

  // one strobe, then the register chosen by s is compared with e
  task automatic go(input logic d, i, s, input logic [35:0] e);
    data_alpha <= d;
    instr_alpha <= i;
    @(posedge aclk);
    {data_alpha, instr_alpha, mem_strobe, file_step_timer} <= 4'h0;
    rnd();
    q.push_back({2'h0, e});
    chk_sel <= s;
    chk_dp <= 1'b1;
    @(posedge aclk);
    chk_dp <= 1'b0;
  endtask

  task automatic ld();
    op_class <= OP_NONE;
    mem_strobe <= 1'b1;
    bv = mem_word;
    go(0, 0, 1, bv);
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    int n;
    q.push_back({36'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    if (n >= 50) failures++;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int n;
    q.push_back({4'h0, e});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    if (n >= 50) failures++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic note();
    tn++;
    $display("test %0d done", tn);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge aclk);
    failures++;
    close_out();
  end

  initial begin
    seed = 32'h4a63918e;
    {aresetn, data_alpha, instr_alpha, file_step_timer, file_rot_left} = 5'h0;
    {defer_cycle, chg_seq_cycle, uses_flipflop_space, instr_in_arith} = 4'h0;
    {operand_in_arith, shift_dir_level, mem_strobe, store_alarm_lock} = 4'h0;
    {chk_dp, chk_sel, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, clk_en, slow} = 4'h3;
    {op_class, io_mode, data_cycle_timer, instr_cycle_timer} = 16'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    {bv, ev} = 72'h0;
    rnd();
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    slow <= 1'b0;
    repeat (3) @(posedge aclk);
    ld();
    store_alarm_lock <= 1'b1;
    mem_strobe <= 1'b1;
    go(0, 0, 1, bv);
    op_class <= OP_STORE;
    data_cycle_timer <= 5'h12;
    go(1, 0, 1, bv);
    rd(32'h4, {2'h0, 32'h2});
    store_alarm_lock <= 1'b0;
    go(1, 0, 1, 36'h0);
    note();
    ld();
    op_class <= OP_LOAD;
    data_cycle_timer <= 5'h17;
    go(1, 0, 0, bv);
    ld();
    op_class <= OP_STORE;
    data_cycle_timer <= 5'h15;
    go(1, 0, 0, bv);
    ev = bv;
    ld();
    op_class <= OP_ZERO_MERGE;
    data_cycle_timer <= 5'h0d;
    ev = ev & bv;
    go(1, 0, 0, ev);
    io_mode <= IOM_ASSEMBLY;
    for (int k = 0; k < 4; k++) begin
      ld();
      op_class <= ops[k];
      go(1, 0, 0, bv);
    end
    ev = bv;
    io_mode <= IOM_NORMAL;
    op_class <= OP_NONE;
    operand_in_arith <= 1'b1;
    data_cycle_timer <= 5'h03;
    ev = arith_word;
    go(1, 0, 0, ev);
    slow <= 1'b1;
    repeat (2) @(posedge aclk);
    go(1, 0, 0, ev);
    slow <= 1'b0;
    operand_in_arith <= 1'b0;
    repeat (2) @(posedge aclk);
    op_class <= OP_IO_MOVE;
    io_mode <= IOM_IN;
    data_cycle_timer <= 5'h0d;
    ev = io_input_mixer;
    go(1, 0, 0, ev);
    io_mode <= IOM_NORMAL;
    note();
    ld();
    defer_cycle <= 1'b1;
    instr_cycle_timer <= 5'h0b;
    go(0, 1, 0, bv);
    instr_cycle_timer <= 5'h0c;
    ev = {bv[35:24], data_cycle_config[5:0], index_sum};
    go(0, 1, 0, ev);
    defer_cycle <= 1'b0;
    chg_seq_cycle <= 1'b1;
    ev = {ev[35:33], flow_tag[23:18], ev[26:24], fetch_word[23:18],
      next_instr_addr};
    go(0, 1, 0, ev);
    chg_seq_cycle <= 1'b0;
    op_class <= OP_FLOAD_FULL;
    data_cycle_timer <= 5'h03;
    ev = {data_cycle_config, ev[26:0]};
    go(1, 0, 0, ev);
    for (int k = 0; k < 2; k++) begin
      file_rot_left <= (k == 0);
      file_step_timer <= 1'b1;
      ev = k ? {ev[8:0], ev[35:9]} : {ev[26:0], ev[35:27]};
      go(0, 0, 0, ev);
    end
    note();
    ld();
    op_class <= OP_SKIP_DIFF;
    data_cycle_timer <= 5'h0d;
    data_alpha <= 1'b1;
    @(posedge aclk);
    data_cycle_timer <= 5'h0f;
    go(1, 0, 0, ev);
    op_class <= OP_MERGE_INTO;
    data_cycle_timer <= 5'h0d;
    bv = bv & ev;
    go(1, 0, 1, bv);
    data_cycle_timer <= 5'h13;
    bv = bv | ev;
    go(1, 0, 1, bv);
    op_class <= OP_IO_MOVE;
    io_mode <= IOM_ASSEMBLY;
    shift_dir_level <= 1'b1;
    data_cycle_timer <= 5'h12;
    go(1, 0, 1, 36'h0);
    data_cycle_timer <= 5'h13;
    go(1, 0, 1, {ev[0], ev[35:1]});
    io_mode <= IOM_NORMAL;
    note();
    wr(32'h0, 32'h5, 2'h0);
    rd(32'h0, {2'h0, 32'h5});
    ld();
    op_class <= OP_STORE;
    data_cycle_timer <= 5'h0d;
    go(1, 0, 1, {bv[35:27], ev[26:18], bv[17:9], ev[8:0]});
    wr(32'h0, 32'hf, 2'h0);
    rd(32'h8, {2'h0, ev[31:0]});
    rd(32'hc, {2'h0, 28'h0, ev[35:32]});
    rd(32'h18, {2'h2, 32'h0});
    wr(32'h4, 32'h1, 2'h2);
    note();
    ld();
    op_class <= OP_LOAD;
    data_cycle_timer <= 5'h0d;
    go(1, 0, 0, bv);
    ld();
    uses_flipflop_space <= 1'b1;
    instr_cycle_timer <= 5'h0b;
    go(0, 1, 0, bv);
    uses_flipflop_space <= 1'b0;
    op_class <= OP_JUMP;
    instr_cycle_timer <= 5'h0c;
    instr_cycle_config <= 9'h018;
    ev = {next_instr_addr, data_addr};
    go(0, 1, 0, ev);
    op_class <= OP_IO_SELECT;
    instr_cycle_config <= 9'h001;
    ev = {ev[35:24], fetch_word[23:18], ev[17:0]};
    go(0, 1, 0, ev);
    instr_in_arith <= 1'b1;
    instr_cycle_timer <= 5'h0a;
    ev = arith_word;
    go(0, 1, 0, ev);
    slow <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(32'h4, {2'h0, 32'h1});
    slow <= 1'b0;
    instr_in_arith <= 1'b0;
    repeat (2) @(posedge aclk);
    ld();
    op_class <= OP_IO_MOVE;
    io_mode <= IOM_NORMAL;
    data_cycle_timer <= 5'h0d;
    go(1, 0, 1, ev);
    note();
    close_out();
  end
endmodule
